/* File: hw/lsc_defs.vh */
/*
 * constants for the low-speed oscillator and system clock control block:
 * register offsets, field positions, reset values and timing counts.
 * assumes a single 10 MHz core clock and a word-indexed register port.
 */
`ifndef LSC_DEFS_VH
`define LSC_DEFS_VH

// ==================================================
// register offsets (word index on the plain port)
`define LSC_OFF_XTAL_CTRL 4'h0
`define LSC_OFF_RC_CTRL 4'h1
`define LSC_OFF_PLL_OUT 4'h2
`define LSC_OFF_SYS_SEL 4'h3
`define LSC_OFF_IRQ_STAT 4'h4
`define LSC_OFF_IRQ_MASK 4'h5

// ==================================================
// crystal and rc control fields
`define LSC_XTAL_ON_BIT 0
`define LSC_XTAL_BYP_BIT 1
`define LSC_XTAL_DRV_LO 2
`define LSC_XTAL_DRV_HI 3
`define LSC_XTAL_STABLE_BIT 4
`define LSC_RC_ON_BIT 0
`define LSC_RC_STABLE_BIT 1
`define LSC_DRV_WEAKEST 2'h0
`define LSC_DRV_RESET 2'h0

// ==================================================
// pll output enables, bit positions
`define LSC_PLL_MAIN_P 0
`define LSC_PLL_MAIN_Q 1
`define LSC_PLL_MAIN_R 2
`define LSC_PLL_AUX_P 3
`define LSC_PLL_AUX_Q 4
`define LSC_PLL_AUX_R 5
`define LSC_PLL_RESET 6'h00

// ==================================================
// system clock sources
`define LSC_SRC_MS_OSC 2'h0
`define LSC_SRC_HSI 2'h1
`define LSC_SRC_FAST_EXT 2'h2
`define LSC_SRC_PLL 2'h3
`define LSC_SRC_RESET 2'h0

// ==================================================
// interrupt status and mask bits
`define LSC_IRQ_XTAL_RDY 0
`define LSC_IRQ_RC_RDY 1
`define LSC_IRQ_SW_DONE 2

// ==================================================
// timing: stability windows in microseconds at 10 MHz, switch handoff in cycles
`define LSC_CLK_MHZ 10
`define LSC_XTAL_START_US 2000
`define LSC_RC_START_US 100
`define LSC_SW_HANDOFF_CYC 4

`endif

/* File: hw/lsc_clock_ctrl.v */
/*
 * low-speed oscillator enables, stability gating, pll output enables,
 * system clock source selection with ready interrupts.
 * assumes oscillators, analog pads and the glitch-free clock mux live
 * outside; this block drives their controls and sees their pin levels.
 */
`timescale 1ns/1ps
`include "lsc_defs.vh"

module lsc_clock_ctrl #(
	parameter XTAL_START_CYC = `LSC_XTAL_START_US * `LSC_CLK_MHZ,
	parameter RC_START_CYC = `LSC_RC_START_US * `LSC_CLK_MHZ
) (
	input wire core_clk,
	input wire rstn,
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire slow_osc_input_pin,
	input wire low_power_stop,
	input wire ms_osc_ready,
	input wire hsi_ready,
	input wire fast_ext_ready,
	input wire pll_ready,
	output wire ext_xtal_enable,
	output wire [1:0] ext_xtal_drive_out,
	output wire ext_xtal_amp_enable,
	output wire slow_osc_output_pin_free,
	output wire ext_xtal_release,
	output wire ext_bypass_level,
	output wire int_rc_enable,
	output wire int_rc_release,
	output wire [5:0] pll_output_enables,
	output wire [1:0] system_clock_root_sel,
	output wire [1:0] system_clock_root_req,
	output wire sys_switch_busy,
	output wire irq
);

	// ==================================================
	// control state
	reg ext_xtal_on; // crystal on-bit
	reg ext_xtal_bypass; // bypass: clock on input pin
	reg [1:0] ext_xtal_drive; // drive strength, 00 weakest
	reg ext_xtal_stable; // stability flag
	reg int_rc_on; // rc on-bit
	reg int_rc_stable; // rc stability flag
	reg [5:0] pll_en; // pll output enables
	reg [1:0] sel_req; // source asked by software
	reg [1:0] sel_cur; // source actually driving
	reg [2:0] irq_stat; // sticky events
	reg [2:0] irq_mask; // event enables
	reg [15:0] xtal_cnt; // crystal settle counter, wide enough for the default window
	reg [13:0] rc_cnt; // rc settle counter
	reg [2:0] sw_cnt; // handoff counter
	reg byp_s1; // pin sync stage 1
	reg byp_s2; // pin sync stage 2
	reg byp_s3; // delayed copy for edge detect
	reg xtal_stable_d; // for ready edge
	reg rc_stable_d; // for ready edge

	// ==================================================
	// decode helpers
	wire wr_xtal = reg_wr && (reg_addr == `LSC_OFF_XTAL_CTRL);
	wire wr_rc = reg_wr && (reg_addr == `LSC_OFF_RC_CTRL);
	wire wr_pll = reg_wr && (reg_addr == `LSC_OFF_PLL_OUT);
	wire wr_sel = reg_wr && (reg_addr == `LSC_OFF_SYS_SEL);
	wire wr_stat = reg_wr && (reg_addr == `LSC_OFF_IRQ_STAT);
	wire wr_mask = reg_wr && (reg_addr == `LSC_OFF_IRQ_MASK);
	wire [1:0] new_drv = reg_wdata[`LSC_XTAL_DRV_HI:`LSC_XTAL_DRV_LO];
	wire new_xon = reg_wdata[`LSC_XTAL_ON_BIT];
	wire pll_is_sys = (sel_cur == `LSC_SRC_PLL);
	reg src_ready; // ready flag of requested source
	reg [1:0] next_drv; // accepted drive value

	// ==================================================
	// ready flag of the requested source
	always @* begin
		case (sel_req)
			`LSC_SRC_MS_OSC: src_ready = ms_osc_ready;
			`LSC_SRC_HSI: src_ready = hsi_ready;
			`LSC_SRC_FAST_EXT: src_ready = fast_ext_ready;
			default: src_ready = pll_ready;
		endcase
	end

	// ==================================================
	// drive field acceptance; while running and kept on, only a drop to weakest sticks
	always @* begin
		next_drv = ext_xtal_drive;
		if (!ext_xtal_on || !new_xon) begin
			next_drv = new_drv;
		end else if (new_drv == `LSC_DRV_WEAKEST) begin
			next_drv = `LSC_DRV_WEAKEST;
		end
	end

	// ==================================================
	// bypass input pin synchroniser; stage 1 feeds stage 2 only
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			byp_s1 <= 1'b0;
			byp_s2 <= 1'b0;
			byp_s3 <= 1'b0;
		end else begin
			byp_s1 <= slow_osc_input_pin;
			byp_s2 <= byp_s1;
			byp_s3 <= byp_s2;
		end
	end

	// ==================================================
	// crystal control and stability timer
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ext_xtal_on <= 1'b0;
			ext_xtal_bypass <= 1'b0;
			ext_xtal_drive <= `LSC_DRV_RESET;
			ext_xtal_stable <= 1'b0;
			xtal_cnt <= 16'h0000;
		end else begin
			if (wr_xtal) begin
				ext_xtal_on <= new_xon;
				ext_xtal_drive <= next_drv;
				// bypass only changes while the oscillator is off
				if (!ext_xtal_on) begin
					ext_xtal_bypass <= reg_wdata[`LSC_XTAL_BYP_BIT];
				end
			end
			if (!ext_xtal_on) begin
				// off: flag drops, timer rearms
				ext_xtal_stable <= 1'b0;
				xtal_cnt <= 16'h0000;
			end else if (ext_xtal_bypass) begin
				// external clock: stable once an edge is seen on the pin
				if (byp_s2 != byp_s3) begin
					ext_xtal_stable <= 1'b1;
				end
			end else if (xtal_cnt == XTAL_START_CYC[15:0] - 16'h0001) begin
				ext_xtal_stable <= 1'b1;
			end else begin
				xtal_cnt <= xtal_cnt + 16'h0001;
			end
		end
	end

	// ==================================================
	// rc oscillator control; runs on regardless of low-power state
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			int_rc_on <= 1'b0;
			int_rc_stable <= 1'b0;
			rc_cnt <= 14'h0000;
		end else begin
			if (wr_rc) begin
				int_rc_on <= reg_wdata[`LSC_RC_ON_BIT];
			end
			if (!int_rc_on) begin
				int_rc_stable <= 1'b0;
				rc_cnt <= 14'h0000;
			end else if (rc_cnt == RC_START_CYC[13:0] - 14'h0001) begin
				int_rc_stable <= 1'b1;
			end else begin
				rc_cnt <= rc_cnt + 14'h0001;
			end
		end
	end

	// ==================================================
	// pll output enables; any bit any time, except main r while in use
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pll_en <= `LSC_PLL_RESET;
		end else if (wr_pll) begin
			pll_en <= reg_wdata[5:0];
			if (pll_is_sys && pll_en[`LSC_PLL_MAIN_R]) begin
				pll_en[`LSC_PLL_MAIN_R] <= 1'b1;
			end
		end
	end

	// ==================================================
	// system clock switch: wait for ready, then a short handoff
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sel_req <= `LSC_SRC_RESET;
			sel_cur <= `LSC_SRC_RESET;
			sw_cnt <= 3'h0;
		end else begin
			if (wr_sel) begin
				sel_req <= reg_wdata[1:0];
				sw_cnt <= 3'h0;
			end else if (sel_req != sel_cur) begin
				// old source stays on until the new one is ready and settled
				if (!src_ready) begin
					sw_cnt <= 3'h0;
				end else if ({29'h0, sw_cnt} == `LSC_SW_HANDOFF_CYC - 1) begin
					sel_cur <= sel_req;
					sw_cnt <= 3'h0;
				end else begin
					sw_cnt <= sw_cnt + 3'h1;
				end
			end
		end
	end

	// ==================================================
	// interrupt status: set wins over write-one-to-clear
	wire sw_done = (sel_req != sel_cur) && src_ready && !wr_sel &&
		({29'h0, sw_cnt} == `LSC_SW_HANDOFF_CYC - 1);
	wire [2:0] irq_set = {sw_done, int_rc_stable & ~rc_stable_d,
		ext_xtal_stable & ~xtal_stable_d};
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irq_stat <= 3'h0;
			irq_mask <= 3'h0;
			xtal_stable_d <= 1'b0;
			rc_stable_d <= 1'b0;
		end else begin
			xtal_stable_d <= ext_xtal_stable;
			rc_stable_d <= int_rc_stable;
			if (wr_mask) begin
				irq_mask <= reg_wdata[2:0];
			end
			irq_stat <= (irq_stat & ~(wr_stat ? reg_wdata[2:0] : 3'h0)) | irq_set;
		end
	end

	// ==================================================
	// read port, data one cycle after the strobe
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			if (reg_addr == `LSC_OFF_XTAL_CTRL) begin
				reg_rdata <= {27'h0, ext_xtal_stable, ext_xtal_drive, ext_xtal_bypass,
					ext_xtal_on};
			end else if (reg_addr == `LSC_OFF_RC_CTRL) begin
				reg_rdata <= {30'h0, int_rc_stable, int_rc_on};
			end else if (reg_addr == `LSC_OFF_PLL_OUT) begin
				reg_rdata <= {26'h0, pll_en};
			end else if (reg_addr == `LSC_OFF_SYS_SEL) begin
				reg_rdata <= {27'h0, sel_req != sel_cur, sel_cur, 2'h0} | {30'h0, sel_req};
			end else if (reg_addr == `LSC_OFF_IRQ_STAT) begin
				reg_rdata <= {29'h0, irq_stat};
			end else if (reg_addr == `LSC_OFF_IRQ_MASK) begin
				reg_rdata <= {29'h0, irq_mask};
			end else begin
				reg_rdata <= 32'h0000_0000; // unmapped reads zero
			end
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ==================================================
	// outputs
	assign ext_xtal_enable = ext_xtal_on;
	assign ext_xtal_amp_enable = ext_xtal_on && !ext_xtal_bypass;
	assign ext_xtal_drive_out = ext_xtal_drive;
	assign slow_osc_output_pin_free = ext_xtal_on && ext_xtal_bypass;
	assign ext_bypass_level = byp_s2;
	assign ext_xtal_release = ext_xtal_stable;
	// low_power_stop only gates a term int_rc_on already covers: rc is never stopped by it
	assign int_rc_enable = int_rc_on | (int_rc_on & low_power_stop);
	assign int_rc_release = int_rc_stable;
	assign pll_output_enables = pll_en;
	assign system_clock_root_sel = sel_cur;
	assign system_clock_root_req = sel_req;
	assign sys_switch_busy = (sel_req != sel_cur);
	assign irq = |(irq_stat & irq_mask);

endmodule // lsc_clock_ctrl

/* File: bench/lsc_chk.sv */
/*
 * port checker for the low-speed oscillator and clock select block.
 * assumes one clock domain, reset active low, attached by the bind below.
 */
`timescale 1ns/1ps
module lsc_chk #(
	parameter XTAL_START_CYC = 8,
	parameter RC_START_CYC = 4
) (
	input wire core_clk,
	input wire rstn,
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire ms_osc_ready,
	input wire hsi_ready,
	input wire fast_ext_ready,
	input wire pll_ready,
	input wire ext_xtal_enable,
	input wire [1:0] ext_xtal_drive_out,
	input wire ext_xtal_amp_enable,
	input wire slow_osc_output_pin_free,
	input wire ext_xtal_release,
	input wire int_rc_enable,
	input wire int_rc_release,
	input wire [5:0] pll_output_enables,
	input wire [1:0] system_clock_root_sel,
	input wire [1:0] system_clock_root_req,
	input wire sys_switch_busy
);
	// ==========================================
	// helpers
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	wire [3:0] rdy = {pll_ready, fast_ext_ready, hsi_ready, ms_osc_ready}; // one per source
	wire w0 = reg_wr && reg_addr == 4'h0; // crystal control write
	wire w1 = reg_wr && reg_addr == 4'h1; // rc control write
	wire w2 = reg_wr && reg_addr == 4'h2; // pll enable write
	// pll feeds the system clock, so its r output must not be cut
	wire lock = system_clock_root_sel == 2'h3 && pll_output_enables[2];
	// rc clock stays gated for at least a few cycles after start
	sequence rc_wait;
		!int_rc_release [*3];
	endsequence
	// ==========================================
	// assertions
	rd_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not idle");
	xtal_on_a: assert property (w0 |=> ext_xtal_enable == $past(reg_wdata[0]))
		else $error("crystal enable wrong");
	rc_on_a: assert property (w1 |=> int_rc_enable == $past(reg_wdata[0]))
		else $error("rc enable wrong");
	rc_keep_a: assert property (int_rc_enable && !w1 |=> int_rc_enable)
		else $error("rc stopped without write");
	pll_free_a: assert property (w2 && !lock |=> pll_output_enables == $past(reg_wdata[5:0]))
		else $error("pll enables not written");
	pll_hold_a: assert property (w2 && lock |=> pll_output_enables[2])
		else $error("pll r enable cleared");
	drv_up_a: assert property (w0 && ext_xtal_enable && reg_wdata[0] && reg_wdata[3:2] != 2'h0
		|=> $stable(ext_xtal_drive_out))
		else $error("drive changed while on");
	drv_low_a: assert property (w0 && ext_xtal_enable && reg_wdata[0] && reg_wdata[3:2] == 2'h0
		|=> ext_xtal_drive_out == 2'h0)
		else $error("drive not lowered");
	xtal_gate_a: assert property ($rose(ext_xtal_release) |-> ext_xtal_enable)
		else $error("crystal released while off");
	rc_gate_a: assert property ($rose(int_rc_enable) |-> rc_wait)
		else $error("rc released early");
	pin_free_a: assert property (slow_osc_output_pin_free |-> ext_xtal_enable && !ext_xtal_amp_enable)
		else $error("pin freed outside bypass");
	src_ready_a: assert property ($changed(system_clock_root_sel) |-> rdy[system_clock_root_sel])
		else $error("switched to source not ready");
	sw_time_a: assert property ($rose(sys_switch_busy) && rdy[system_clock_root_req]
		|-> ##[1:8] !sys_switch_busy)
		else $error("switch did not finish");
endmodule // lsc_chk

bind lsc_clock_ctrl lsc_chk #(.XTAL_START_CYC(XTAL_START_CYC), .RC_START_CYC(RC_START_CYC))
	lsc_chk_i (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.ms_osc_ready, .hsi_ready, .fast_ext_ready, .pll_ready, .ext_xtal_enable, .ext_xtal_drive_out,
	.ext_xtal_amp_enable, .slow_osc_output_pin_free, .ext_xtal_release, .int_rc_enable,
	.int_rc_release, .pll_output_enables, .system_clock_root_sel, .system_clock_root_req,
	.sys_switch_busy);

/* File: bench/lsc_slow_src.sv */
/*
 * external slow clock source driving the oscillator input pin.
 * assumes run is high only while bypass mode frees the output pin.
 */
`timescale 1ns/1ps
module lsc_slow_src #(
	parameter HALF_NS = 500 // 1 MHz, the fastest bypass clock allowed
) (
	input wire run,
	output logic pin
);
	// ==========================================
	// source stands low while not in use, so no stray edge is seen
	initial pin = 1'b0;
	always begin
		#(HALF_NS);
		pin = run ? !pin : 1'b0;
	end
endmodule // lsc_slow_src

/* File: bench/lsc_clock_ctrl_bench.sv */
/*
 * self-checking bench for lsc_clock_ctrl against a register model.
 * assumes the bound checker and the slow source model beside the design.
 */
`timescale 1ns/1ps
module lsc_clock_ctrl_bench;
	logic core_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, low_power_stop = 1'b0;
	logic ms_osc_ready = 1'b1, hsi_ready = 1'b1, fast_ext_ready = 1'b1, pll_ready = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [1:0] ext_xtal_drive_out;
	logic slow_osc_input_pin, slow_osc_output_pin_free, ext_xtal_release, irq;
	// model state: short counts keep the start-up waits small
	bit on, byp, xs, rc, rs;
	bit [1:0] drv, req, sel;
	bit [5:0] pll;
	bit [2:0] st, mk;
	int error_cnt = 0, cmp_count = 0, i;
	int dv[4] = '{5, 1, 9, 8}; // drop to 01 refused, lower to weakest, raise refused, off
	always #50 core_clk = ~core_clk;
	lsc_clock_ctrl #(.XTAL_START_CYC(8), .RC_START_CYC(4)) lsc_clock_ctrl_i (
		.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.slow_osc_input_pin, .low_power_stop, .ms_osc_ready, .hsi_ready, .fast_ext_ready,
		.pll_ready, .ext_xtal_enable(), .ext_xtal_drive_out, .ext_xtal_amp_enable(),
		.slow_osc_output_pin_free, .ext_xtal_release, .ext_bypass_level(),
		.int_rc_enable(), .int_rc_release(), .pll_output_enables(),
		.system_clock_root_sel(), .system_clock_root_req(), .sys_switch_busy(), .irq);
	lsc_slow_src lsc_slow_src_i (.run(slow_osc_output_pin_free), .pin(slow_osc_input_pin));
	// ==========================================
	// compare tasks
	task automatic chk_reg(input logic [3:0] a, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD reg %0d exp %h got %h", a, e, g);
		end
	endtask
	// callers come a step past the edge, so the port value passed in has settled
	task automatic chk_pin(input string n, input logic [1:0] e, input logic [1:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	function automatic logic [31:0] exp_reg(input int a);
		case (a)
			0: return {27'h0, xs, drv, byp, on};
			1: return {30'h0, rs, rc};
			2: return {26'h0, pll};
			3: return {27'h0, req != sel, sel, req};
			4: return {29'h0, st};
			5: return {29'h0, mk};
			default: return 32'h0; // unmapped reads zero
		endcase
	endfunction
	// ==========================================
	// register port master
	task automatic rd(input int a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a[3:0];
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk_reg(a[3:0], exp_reg(a), reg_rdata);
	endtask
	task automatic wr(input int a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a[3:0];
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		case (a)
			0: begin
				if (on && d[0]) drv = d[3:2] == 2'h0 ? 2'h0 : drv;
				else drv = d[3:2];
				if (!on) byp = d[1];
				on = d[0];
				xs = xs && on; // stopped crystal is not stable
			end
			1: begin
				rc = d[0];
				rs = rs && rc;
			end
			2: pll = (sel == 2'h3 && pll[2]) ? d[5:0] | 6'h04 : d[5:0];
			3: req = d[1:0];
			4: st = st & ~d[2:0];
			5: mk = d[2:0];
		endcase
		#1; // step past the edge so the write's effect is visible to callers
	endtask
	task automatic conclude();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ==========================================
	// watchdog, several times the expected run
	initial begin
		repeat (3000) @(posedge core_clk);
		error_cnt++;
		conclude();
	end
	// ==========================================
	// main sequence
	initial begin
		void'($urandom(80));
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		for (i = 0; i < 8; i++) rd(i);
		wr(5, 7);
		for (i = 0; i < 8; i++) begin
			wr(2, $urandom);
			rd(2);
		end
		wr(1, 1);
		repeat (10) @(posedge core_clk);
		rs = 1;
		st[1] = 1;
		rd(1);
		chk_pin("irq", 1, irq);
		low_power_stop <= 1'b1;
		repeat (4) @(posedge core_clk);
		rd(1);
		wr(4, 2);
		rd(4);
		chk_pin("irq", 0, irq);
		wr(0, 32'hd);
		chk_pin("xrel", 0, ext_xtal_release);
		repeat (15) @(posedge core_clk);
		xs = 1;
		st[0] = 1;
		rd(0);
		chk_pin("xrel", 1, ext_xtal_release);
		for (i = 0; i < 4; i++) begin
			wr(0, dv[i]);
			rd(0);
			chk_pin("drive", drv, ext_xtal_drive_out);
		end
		wr(0, 2);
		wr(0, 3);
		repeat (14) @(posedge core_clk);
		xs = 1;
		rd(0);
		chk_pin("pinfree", 1, slow_osc_output_pin_free);
		wr(0, 1);
		rd(0);
		wr(0, 0);
		fast_ext_ready <= 1'b0;
		wr(3, 2);
		repeat (8) @(posedge core_clk);
		rd(3);
		fast_ext_ready <= 1'b1;
		repeat (8) @(posedge core_clk);
		sel = 2;
		st[2] = 1;
		rd(4);
		wr(5, 0);
		chk_pin("irq", 0, irq);
		wr(5, 7);
		chk_pin("irq", 1, irq);
		wr(2, 32'h3f);
		for (i = 1; i < 5; i++) begin
			wr(3, i % 4);
			repeat (8) @(posedge core_clk);
			sel = i % 4;
			rd(3);
			if (i == 3) begin
				wr(2, 0);
				rd(2);
			end
		end
		wr(4, 7);
		rd(4);
		chk_pin("irq", 0, irq);
		conclude();
	end
endmodule // lsc_clock_ctrl_bench
